/* core/ccp_completion_port.sv */
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module ccp_completion_port (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic completion_in_valid,
    output logic completion_in_ready,
    input wire logic [ccp_pkg::DATA_W-1:0] completion_in_data,
    input wire logic completion_in_last,
    input wire logic [ccp_pkg::SIDE_W-1:0] completion_in_sideband,
    input wire logic link_ready,
    output logic tlp_valid,
    output logic [ccp_pkg::DATA_W-1:0] tlp_data,
    output logic tlp_last,
    output logic tlp_nullify,
    output logic tlp_ecrc,
    output logic [2:0] tlp_attr,
    output logic [7:0] completer_bus,
    output logic [4:0] completer_dev,
    output logic aer_internal_error,
    input wire logic config_id_load,
    input wire logic [7:0] config_bus,
    input wire logic [4:0] config_dev,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef struct packed {
        logic in_pkt;
        logic [1:0] beat;
        logic desc_done;
        logic err_gap;
        logic err_disc;
        logic [31:0] ctrl;
        logic [7:0] cap_bus;
        logic [4:0] cap_dev;
        logic [15:0] pkt_cnt;
        logic [15:0] null_cnt;
        logic [5:0] last_desc;
        logic out_valid;
        logic [ccp_pkg::DATA_W-1:0] out_data;
        logic out_last;
        logic out_null;
        logic out_ecrc;
        logic [2:0] out_attr;
        logic [7:0] out_bus;
        logic [4:0] out_dev;
        logic aer;
        logic ack;
        logic [31:0] rdata;
    } ccp_state_type;

    ccp_state_type st;
    ccp_state_type next_st;

    // beat that carries descriptor dword 2 for a width code
    function automatic logic [1:0] dw2_beat(input logic [1:0] width);
        dw2_beat = (width == ccp_pkg::WIDTH_64) ? 2'h1 : 2'h0;
    endfunction

    // descriptor dword 2 as it sits on the data lanes
    function automatic logic [31:0] dw2_of(input logic [1:0] width, input logic [ccp_pkg::DATA_W-1:0] d);
        dw2_of = (width == ccp_pkg::WIDTH_64) ? d[31:0] : d[ccp_pkg::DW2_LANE_LO +: 32];
    endfunction

    // byte-lane merge of a bus write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    logic [1:0] width;
    logic accept;
    logic disc;
    logic err_now;
    logic [31:0] dw2;
    logic wb_req;

    assign width = st.ctrl[ccp_pkg::CTRL_WIDTH_LO +: 2];
    // ready follows the link, gated by the enable bit; the port may stall any cycle
    assign completion_in_ready = link_ready & st.ctrl[ccp_pkg::CTRL_ENABLE];
    assign accept = completion_in_valid & completion_in_ready;
    // discontinue only counts on a taken beat
    assign disc = completion_in_sideband[ccp_pkg::DISC_BIT];
    assign err_now = st.err_disc | disc | st.err_gap;
    assign dw2 = dw2_of(width, completion_in_data);
    assign wb_req = wb_cyc_i & wb_stb_i;

    // next-state logic for stream, registers and bus
    always_comb begin
        next_st = st;
        next_st.out_valid = 1'b0;
        next_st.aer = 1'b0;
        next_st.ack = 1'b0;
        if (config_id_load) begin
            next_st.cap_bus = config_bus;
            next_st.cap_dev = config_dev;
        end
        // valid gap inside a packet poisons it
        if (st.in_pkt && !completion_in_valid) begin
            next_st.err_gap = 1'b1;
        end
        if (accept) begin
            next_st.out_valid = 1'b1;
            next_st.out_data = completion_in_data;
            next_st.out_last = completion_in_last;
            next_st.out_null = completion_in_last & err_now;
            if (disc) begin
                next_st.err_disc = 1'b1;
            end
            if (st.beat != 2'h3) begin
                next_st.beat = st.beat + 2'h1;
            end
            // descriptor dword 2 position depends on width
            if (!st.desc_done && st.beat == dw2_beat(width)) begin
                next_st.desc_done = 1'b1;
                next_st.out_attr = dw2[ccp_pkg::DESC_ATTR_LO +: 3];
                next_st.out_ecrc = dw2[ccp_pkg::DESC_ECRC];
                if (dw2[ccp_pkg::DESC_CID_EN]) begin
                    next_st.out_bus = dw2[ccp_pkg::DESC_BUS_LO +: 8];
                    next_st.out_dev = dw2[ccp_pkg::DESC_DEV_LO +: 5];
                end else begin
                    next_st.out_bus = st.cap_bus;
                    next_st.out_dev = st.cap_dev;
                end
                next_st.last_desc[4:0] = {dw2[ccp_pkg::DESC_CID_EN], dw2[ccp_pkg::DESC_ECRC],
                    dw2[ccp_pkg::DESC_ATTR_LO +: 3]};
            end
            // packet end frees the port for the very next beat
            if (completion_in_last) begin
                next_st.in_pkt = 1'b0;
                next_st.beat = 2'h0;
                next_st.desc_done = 1'b0;
                next_st.err_gap = 1'b0;
                next_st.err_disc = 1'b0;
                next_st.pkt_cnt = st.pkt_cnt + 16'h0001;
                next_st.last_desc[5] = err_now;
                if (err_now) begin
                    next_st.null_cnt = st.null_cnt + 16'h0001;
                end
                next_st.aer = st.ctrl[ccp_pkg::CTRL_ENDPOINT] & (st.err_disc | disc);
            end else begin
                next_st.in_pkt = 1'b1;
            end
        end
        // classic wishbone slave, one wait state
        if (wb_req && !st.ack) begin
            next_st.ack = 1'b1;
            unique case (wb_adr_i)
                ccp_pkg::REG_CTRL: next_st.rdata = st.ctrl;
                ccp_pkg::REG_CAPTURED_ID: next_st.rdata = {16'h0000, st.cap_bus, st.cap_dev, 3'h0};
                ccp_pkg::REG_STATUS: next_st.rdata = {st.null_cnt, st.pkt_cnt};
                ccp_pkg::REG_LAST_DESC: next_st.rdata = {26'h000_0000, st.last_desc};
                default: next_st.rdata = 32'h0000_0000;
            endcase
            if (wb_we_i && wb_adr_i == ccp_pkg::REG_CTRL) begin
                next_st.ctrl = merge(st.ctrl, wb_dat_i, wb_sel_i) & 32'h0000_001f;
            end
        end
    end

    // single state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.ctrl <= ccp_pkg::CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign tlp_valid = st.out_valid;
    assign tlp_data = st.out_data;
    assign tlp_last = st.out_last;
    assign tlp_nullify = st.out_null;
    assign tlp_ecrc = st.out_ecrc;
    assign tlp_attr = st.out_attr;
    assign completer_bus = st.out_bus;
    assign completer_dev = st.out_dev;
    assign aer_internal_error = st.aer;
    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic desc_beat_now;
    assign desc_beat_now = accept && !st.desc_done && st.beat == dw2_beat(width);
    // discontinue seen on a taken beat, for the sampling check
    logic disc_take;
    assign disc_take = accept & disc;

    sequence s_abort_beat;
        accept && disc && !completion_in_last;
    endsequence
    sequence s_abort_end;
        accept && completion_in_last;
    endsequence

    chk_attr_copy: assert property (desc_beat_now |=> tlp_attr == $past(dw2[ccp_pkg::DESC_ATTR_LO +: 3]))
        else $error("attributes not copied");
    chk_ecrc_force: assert property (desc_beat_now |=> tlp_ecrc == $past(dw2[ccp_pkg::DESC_ECRC]))
        else $error("ecrc flag not copied");
    chk_desc_beat_width: assert property (accept && width == ccp_pkg::WIDTH_64 && !st.in_pkt |=> !st.desc_done)
        else $error("64-bit descriptor taken too early");
    chk_gap_nullify: assert property (st.in_pkt && !completion_in_valid ##1 s_abort_end |=> tlp_nullify)
        else $error("valid gap not nullified");
    chk_stall_no_beat: assert property (!completion_in_ready |=> !tlp_valid)
        else $error("beat forwarded while stalled");
    chk_abort_sticky: assert property (s_abort_beat ##1 (!(accept && completion_in_last))[*1] ##1 s_abort_end
        |=> tlp_nullify)
        else $error("abort error not sticky");
    chk_disc_nullify: assert property (accept && disc && completion_in_last |=> tlp_last && tlp_nullify)
        else $error("discontinue not nullified");
    chk_disc_sample: assert property ($rose(st.err_disc) |-> $past(disc_take))
        else $error("discontinue sampled without handshake");
    chk_aer_report: assert property ((s_abort_end and (disc && st.ctrl[ccp_pkg::CTRL_ENDPOINT]))
        |=> aer_internal_error)
        else $error("abort not reported");
    chk_cid_source: assert property (desc_beat_now && !dw2[ccp_pkg::DESC_CID_EN]
        |=> completer_bus == $past(st.cap_bus))
        else $error("captured bus number not used");
    chk_back_to_back: assert property (s_abort_end |=> !st.in_pkt && completion_in_ready == link_ready
        && st.ctrl[ccp_pkg::CTRL_ENABLE] == $past(st.ctrl[ccp_pkg::CTRL_ENABLE]))
        else $error("port not free after last");
endmodule // ccp_completion_port

/* core/ccp_pkg.sv */
package ccp_pkg;
    localparam int DATA_W = 256;
    localparam int SIDE_W = 33;
    localparam int DISC_BIT = 0;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CAPTURED_ID = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_LAST_DESC = 8'h0c;
    // control fields
    localparam int CTRL_ALIGN = 0;
    localparam int CTRL_WIDTH_LO = 1;
    localparam int CTRL_ENDPOINT = 3;
    localparam int CTRL_ENABLE = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_001c;
    // interface width codes
    localparam logic [1:0] WIDTH_64 = 2'h0;
    localparam logic [1:0] WIDTH_128 = 2'h1;
    localparam logic [1:0] WIDTH_256 = 2'h2;
    // descriptor fields, positions inside descriptor dword 2
    localparam int DW2_BASE = 64;
    localparam int DESC_DEV_LO = 75 - DW2_BASE;
    localparam int DESC_BUS_LO = 80 - DW2_BASE;
    localparam int DESC_CID_EN = 88 - DW2_BASE;
    localparam int DESC_ATTR_LO = 92 - DW2_BASE;
    localparam int DESC_ECRC = 95 - DW2_BASE;
    // dword 2 lane position on the wide interfaces
    localparam int DW2_LANE_LO = 64;
endpackage

/* dv/ccp_app_model.sv */
`timescale 1ns/1ns
module ccp_app_model (
    input wire logic core_clk,
    input wire logic ready,
    output logic valid,
    output logic [ccp_pkg::DATA_W-1:0] data,
    output logic last,
    output logic [ccp_pkg::SIDE_W-1:0] side
);
    // quiet port at time zero
    initial begin
        valid = 1'b0;
        data = '0;
        last = 1'b0;
        side = '0;
    end
    // one beat, everything held until the port takes it
    task automatic beat(input logic [ccp_pkg::DATA_W-1:0] d, input logic l, input logic disc);
        valid <= 1'b1;
        data <= d;
        last <= l;
        side <= {{(ccp_pkg::SIDE_W-1){1'b0}}, disc} << ccp_pkg::DISC_BIT;
        do begin
            @(posedge core_clk);
        end while (ready !== 1'b1);
    endtask
    // released port shows inverted data so stale values never match
    task automatic idle();
        valid <= 1'b0;
        last <= 1'b0;
        side <= '0;
        data <= ~data;
        @(posedge core_clk);
    endtask
    // byte count of a request from its byte masks and dword count
    function automatic logic [12:0] byte_count(input logic [3:0] leading_byte_mask,
        input logic [3:0] trailing_byte_mask, input logic [10:0] dwords);
        int first_on;
        int last_on;
        int tail_on;
        first_on = 0;
        last_on = 0;
        tail_on = 0;
        for (int i = 3; i >= 0; i--) begin
            if (leading_byte_mask[i]) first_on = i;
        end
        for (int i = 0; i < 4; i++) begin
            if (leading_byte_mask[i]) last_on = i;
            if (trailing_byte_mask[i]) tail_on = i;
        end
        // single dword: span of enabled bytes, else whole dwords less disabled ends
        if (trailing_byte_mask == 4'h0) begin
            byte_count = (leading_byte_mask == 4'h0) ? 13'h0001 : 13'(last_on - first_on + 1);
        end else begin
            byte_count = 13'({dwords, 2'b00} - first_on - (3 - tail_on));
        end
    endfunction
    // error completion: descriptor, request sideband dword, request descriptor, packed in one word
    function automatic logic [ccp_pkg::DATA_W-1:0] err_word(input logic [95:0] desc,
        input logic [3:0] leading_byte_mask, input logic [3:0] trailing_byte_mask, input logic hint,
        input logic [1:0] hint_type, input logic [7:0] steering_tag, input logic [127:0] req);
        err_word = {req, 13'h0000, steering_tag, hint_type, hint, trailing_byte_mask, leading_byte_mask, desc};
    endfunction
endmodule // ccp_app_model

/* dv/pcie_completer_completion_port_test.sv */
`timescale 1ns/1ns
module pcie_completer_completion_port_test;
    typedef struct packed {logic [255:0] d; logic l; logic n; logic [3:0] a; logic [12:0] id;} ccp_note_type;
    logic core_clk, rst, link_ready, config_id_load, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] config_bus, wb_adr_i, completer_bus;
    logic [4:0] config_dev, completer_dev;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, seed, rd;
    logic v, rdy, l, tv, tl, tn, te, aer;
    logic [255:0] d, td;
    logic [32:0] s;
    logic [2:0] ta;
    logic [12:0] cap_id;
    ccp_note_type notes[$];
    int n_errors = 0, tests_run = 0, aer_seen = 0, n_aer = 0;
    bit stall_en = 0;
    bit w64 = 0;
    bit amode = 0;
    logic [3:0] pa;
    logic [12:0] pid;
    ccp_app_model app (.core_clk(core_clk), .ready(rdy), .valid(v), .data(d), .last(l), .side(s));
    ccp_completion_port dut (.core_clk(core_clk), .rst(rst), .completion_in_valid(v), .completion_in_ready(rdy),
        .completion_in_data(d), .completion_in_last(l), .completion_in_sideband(s), .link_ready(link_ready),
        .tlp_valid(tv), .tlp_data(td), .tlp_last(tl), .tlp_nullify(tn), .tlp_ecrc(te), .tlp_attr(ta),
        .completer_bus(completer_bus), .completer_dev(completer_dev), .aer_internal_error(aer),
        .config_id_load(config_id_load), .config_bus(config_bus), .config_dev(config_dev), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic chk(input logic [274:0] got, input logic [274:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // classic single wishbone cycle, waits for ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] q);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge core_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    // one completion packet, expectations noted per beat
    task automatic pkt(input int nb, input logic cid, input int dat, input logic gap, input logic ep);
        logic [255:0] x;
        int db;
        int dlo;
        logic bad;
        bad = 0;
        // descriptor dword 2 rides beat 1 at 64 bits, beat 0 otherwise
        db = w64 ? 1 : 0;
        dlo = w64 ? 0 : ccp_pkg::DW2_LANE_LO;
        for (int i = 0; i < nb; i++) begin
            for (int k = 0; k < 8; k++) x[32*k+:32] = rnd();
            if (nb == 1) begin
                x = app.err_word(x[95:0], x[99:96], x[103:100], x[104], x[106:105], x[114:107],
                    x[255:128]);
            end
            if (i == db) begin
                x[dlo + ccp_pkg::DESC_CID_EN] = cid;
                // address mode: lanes after the descriptor stay null, payload opens next beat at lane 0
                if (amode) begin
                    for (int k = dlo / 32 + 1; k < 8; k++) x[32*k+:32] = '0;
                end
                pa = x[dlo + ccp_pkg::DESC_ATTR_LO +: 4];
                pid = cid ? {x[dlo + ccp_pkg::DESC_BUS_LO +: 8], x[dlo + ccp_pkg::DESC_DEV_LO +: 5]} : cap_id;
            end
            // null pad after the last payload byte
            if (i == nb - 1 && i > db) x[255:248] = 8'h00;
            bad |= (i == dat) || (gap && i == nb - 1);
            notes.push_back({x, i == nb - 1, bad && i == nb - 1, pa, pid});
            if (gap && i == nb - 1) app.idle();
            app.beat(x, i == nb - 1, i == dat);
        end
        // only an aborted packet is reported, a valid gap is not
        if (dat >= 0 && dat < nb && ep) n_aer++;
    endtask
    // random stalls from the link side
    always @(posedge core_clk) link_ready <= !stall_en || (rnd() % 4 != 0);
    always @(posedge core_clk) if (aer === 1'b1) aer_seen++;
    // output watcher pairs each forwarded beat with the oldest note
    always @(posedge core_clk) begin
        if (tv === 1'b1) begin
            if (notes.size() == 0) chk(1, 0);
            else chk({td, tl, tn, te, ta, completer_bus, completer_dev}, notes.pop_front());
        end
    end
    initial begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        conclude();
    end
    initial begin
        seed = 32'h392c;
        {rst, link_ready, config_id_load, wb_cyc_i, wb_stb_i, wb_we_i} = 6'b110000;
        {config_bus, config_dev, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        cap_id = {8'h5a, 5'h13};
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        wb(0, ccp_pkg::REG_CTRL, 0, rd);
        chk(rd, ccp_pkg::CTRL_RESET);
        wb(0, 8'h40, 0, rd);
        chk(rd, 0);
        chk(app.byte_count(4'h5, 4'h0, 11'h001), 3);
        chk(app.byte_count(4'h0, 4'h0, 11'h001), 1);
        chk(app.byte_count(4'h8, 4'h1, 11'h003), 6);
        chk(app.byte_count(4'h2, 4'h3, 11'h004), 13);
        config_bus <= 8'h5a;
        config_dev <= 5'h13;
        config_id_load <= 1'b1;
        @(posedge core_clk);
        config_id_load <= 1'b0;
        stall_en = 1;
        pkt(2, 0, -1, 0, 1);
        pkt(3, 1, -1, 0, 1);
        pkt(4, 1, 1, 0, 1);
        pkt(3, 0, -1, 1, 1);
        pkt(1, 1, -1, 0, 1);
        for (int j = 0; j < 6; j++) pkt(2 + j % 3, j % 2, -1, 0, 1);
        app.idle();
        repeat (5) @(posedge core_clk);
        chk(aer_seen, n_aer);
        // 64-bit interface in address mode
        wb(1, ccp_pkg::REG_CTRL, 32'h0000_0019, rd);
        wb(0, ccp_pkg::REG_CTRL, 0, rd);
        chk(rd, 32'h0000_0019);
        w64 = 1;
        amode = 1;
        pkt(3, 1, -1, 0, 1);
        pkt(2, 0, -1, 0, 1);
        app.idle();
        w64 = 0;
        amode = 0;
        wb(1, ccp_pkg::REG_CTRL, 32'h0000_0014, rd);
        pkt(2, 0, 0, 0, 0);
        app.idle();
        repeat (5) @(posedge core_clk);
        chk(aer_seen, n_aer);
        chk(notes.size(), 0);
        wb(0, ccp_pkg::REG_STATUS, 0, rd);
        chk(rd, 32'h0003_000e);
        wb(0, ccp_pkg::REG_LAST_DESC, 0, rd);
        chk(rd, {26'h000_0000, 2'b10, pa});
        wb(0, ccp_pkg::REG_CAPTURED_ID, 0, rd);
        chk(rd, {16'h0000, cap_id, 3'h0});
        conclude();
    end
endmodule // pcie_completer_completion_port_test
